// file: rtl/pll_cfg_pkg.sv
// Constants, register map and carrier types of the PLL ratio clock configuration block
package pll_cfg_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_PLLS = 7;
    localparam int NUM_CORES = 4;
    localparam int NUM_LANES = 3;
    localparam int RAT_W = 5;
    localparam int RANGE_W = 2;
    localparam int SEL_W = 4;
    localparam int LANE_W = 3;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    // PLL index in lock and enable vectors
    localparam int PLL_CLA = 0;
    localparam int PLL_CLB = 1;
    localparam int PLL_PLAT = 2;
    localparam int PLL_DDR = 3;
    localparam int PLL_LANE0 = 4;
    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_PLAT = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_CLUS = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_CSEL = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_MEM = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_MISC = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 5'h18;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int APPLY_BIT = 0;
    localparam int RANGE_LSB = 8;
    localparam int CLB_RAT_LSB = 16;
    localparam int CLB_RANGE_LSB = 24;
    localparam int SYNC_BIT = 16;
    localparam int LANE_LSB = 8;
    localparam int LANE_STRIDE = 4;
    localparam int STAT_EN_LSB = 8;
    localparam int STAT_INV_BIT = 16;
    localparam int STAT_RUN_BIT = 17;
    // ****************************************
    // Codes and reset values
    // ****************************************
    localparam logic [RAT_W-1:0] PLAT_RAT_MIN = 5'h04;
    localparam logic [RAT_W-1:0] PLAT_RAT_MAX = 5'h0a;
    localparam logic [RAT_W-1:0] CLUS_RAT_MIN = 5'h08;
    localparam logic [RAT_W-1:0] CLUS_RAT_MAX = 5'h12;
    localparam logic [RAT_W-1:0] MEM_SYNC_CODE = 5'h01;
    localparam logic [SEL_W-1:0] SEL_A_DIV1 = 4'h0;
    localparam logic [SEL_W-1:0] SEL_A_DIV2 = 4'h1;
    localparam logic [SEL_W-1:0] SEL_B_DIV1 = 4'h4;
    localparam logic [SEL_W-1:0] SEL_B_DIV2 = 4'h5;
    localparam logic [1:0] PME_DIV_RATIO = 2'h2;
    localparam logic [DATA_W-1:0] CFG_RST = 32'h0000_0000;
    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic [RAT_W-1:0] mult;
        logic [RANGE_W-1:0] range;
    } pll_set_t;
    typedef struct packed {
        logic src_b;
        logic div2;
    } core_clk_t;
    typedef enum logic [1:0] {IDLE_ST, LOCK_ST, RUN_ST, FAULT_ST} cfg_state_t;
endpackage : pll_cfg_pkg

// file: rtl/pll_ratio_clock_config.sv
// Configuration decoder and domain gating for the seven on-chip PLLs
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module pll_ratio_clock_config
    import pll_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [pll_cfg_pkg::ADDR_W-1:0] addr,
    input wire logic [pll_cfg_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [pll_cfg_pkg::DATA_W-1:0] rd_data,
    // PLL lock reports
    input wire logic [pll_cfg_pkg::NUM_PLLS-1:0] pll_lock,
    // PLL settings
    output pll_cfg_pkg::pll_set_t cluster_a_set,
    output pll_cfg_pkg::pll_set_t cluster_b_set,
    output pll_cfg_pkg::pll_set_t platform_set,
    output pll_cfg_pkg::pll_set_t memory_set,
    output logic [pll_cfg_pkg::NUM_LANES-1:0][pll_cfg_pkg::LANE_W-1:0] lane_mult,
    // Derived clock relations
    output pll_cfg_pkg::core_clk_t [pll_cfg_pkg::NUM_CORES-1:0] core_clk,
    output logic ddr_ref_platform,
    output logic mem_bus_half,
    output logic [1:0] pme_div,
    output logic [pll_cfg_pkg::RAT_W-1:0] local_bus_div,
    // Gating and status
    output logic [pll_cfg_pkg::NUM_PLLS-1:0] domain_enable,
    output logic config_invalid
);
    import pll_cfg_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [DATA_W-1:0] plat_r, plat_nxt, clus_r, clus_nxt, csel_r, csel_nxt;
    logic [DATA_W-1:0] mem_r, mem_nxt, misc_r, misc_nxt, rd_data_nxt;
    pll_set_t cla_nxt, clb_nxt, plat_set_nxt, mem_set_nxt;
    logic [NUM_LANES-1:0][LANE_W-1:0] lane_nxt;
    core_clk_t [NUM_CORES-1:0] core_dec, core_nxt;
    logic [NUM_CORES-1:0] core_ok;
    logic ddr_ref_nxt, half_nxt, inv_nxt;
    logic [1:0] pme_nxt;
    logic [RAT_W-1:0] lbd_nxt;
    logic [NUM_PLLS-1:0] en_nxt;
    cfg_state_t state_r, state_nxt;
    logic apply, cfg_bad;
    logic [RAT_W-1:0] plat_rat, cla_rat, clb_rat, mem_rat, lb_rat;
    logic mem_sync;

    // Field extraction from the staged configuration
    assign plat_rat = plat_r[RAT_W-1:0];
    assign cla_rat = clus_r[RAT_W-1:0];
    assign clb_rat = clus_r[CLB_RAT_LSB +: RAT_W];
    assign mem_rat = mem_r[RAT_W-1:0];
    assign mem_sync = mem_r[SYNC_BIT];
    assign lb_rat = misc_r[RAT_W-1:0];
    assign apply = wr_en && (addr == ADDR_CTRL) && wr_data[APPLY_BIT];

    // ****************************************
    // Core select decode, one per complex
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CORES; gi++) begin : g_core
            logic [SEL_W-1:0] sel;
            assign sel = csel_r[gi*SEL_W +: SEL_W];
            // Lower pair may halve A; upper pair may halve B
            always_comb begin
                core_ok[gi] = 1'b1;
                core_dec[gi] = '0;
                if (sel == SEL_A_DIV1) begin
                    core_dec[gi] = '0;
                end else if (sel == SEL_B_DIV1) begin
                    core_dec[gi].src_b = 1'b1;
                end else if ((gi < NUM_CORES / 2) && (sel == SEL_A_DIV2)) begin
                    core_dec[gi].div2 = 1'b1;
                end else if ((gi >= NUM_CORES / 2) && (sel == SEL_B_DIV2)) begin
                    core_dec[gi].src_b = 1'b1;
                    core_dec[gi].div2 = 1'b1;
                end else begin
                    core_ok[gi] = 1'b0;
                end
            end
        end
    endgenerate

    // Reserved code anywhere spoils the whole configuration
    always_comb begin
        cfg_bad = 1'b0;
        if ((plat_rat < PLAT_RAT_MIN) || (plat_rat > PLAT_RAT_MAX)) begin
            cfg_bad = 1'b1;
        end
        if ((cla_rat < CLUS_RAT_MIN) || (cla_rat > CLUS_RAT_MAX)) begin
            cfg_bad = 1'b1;
        end
        if ((clb_rat < CLUS_RAT_MIN) || (clb_rat > CLUS_RAT_MAX)) begin
            cfg_bad = 1'b1;
        end
        if (!(&core_ok)) begin
            cfg_bad = 1'b1;
        end
        if (mem_sync && (mem_rat != MEM_SYNC_CODE)) begin
            cfg_bad = 1'b1;
        end
        if (!mem_sync && (mem_rat == '0)) begin
            cfg_bad = 1'b1;
        end
        if (lb_rat == '0) begin
            cfg_bad = 1'b1;
        end
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    // Settings only move on apply, so PLLs never see a half-written set
    always_comb begin
        plat_nxt = plat_r;
        clus_nxt = clus_r;
        csel_nxt = csel_r;
        mem_nxt = mem_r;
        misc_nxt = misc_r;
        cla_nxt = cluster_a_set;
        clb_nxt = cluster_b_set;
        plat_set_nxt = platform_set;
        mem_set_nxt = memory_set;
        lane_nxt = lane_mult;
        core_nxt = core_clk;
        ddr_ref_nxt = ddr_ref_platform;
        half_nxt = mem_bus_half;
        pme_nxt = PME_DIV_RATIO;
        lbd_nxt = local_bus_div;
        en_nxt = domain_enable;
        inv_nxt = config_invalid;
        state_nxt = state_r;
        rd_data_nxt = '0;
        // Staging registers
        if (wr_en) begin
            unique case (addr)
                ADDR_PLAT: plat_nxt = wr_data;
                ADDR_CLUS: clus_nxt = wr_data;
                ADDR_CSEL: csel_nxt = wr_data;
                ADDR_MEM: mem_nxt = wr_data;
                ADDR_MISC: misc_nxt = wr_data;
                default: plat_nxt = plat_r;
            endcase
        end
        // Apply: latch decoded settings and restart lock wait
        if (apply) begin
            cla_nxt = '{mult: cla_rat, range: clus_r[RANGE_LSB +: RANGE_W]};
            clb_nxt = '{mult: clb_rat, range: clus_r[CLB_RANGE_LSB +: RANGE_W]};
            plat_set_nxt = '{mult: plat_rat, range: plat_r[RANGE_LSB +: RANGE_W]};
            mem_set_nxt = '{mult: mem_rat, range: mem_r[RANGE_LSB +: RANGE_W]};
            for (int i = 0; i < NUM_LANES; i++) begin
                lane_nxt[i] = misc_r[LANE_LSB + i*LANE_STRIDE +: LANE_W];
            end
            core_nxt = core_dec;
            ddr_ref_nxt = mem_sync;
            half_nxt = mem_sync;
            lbd_nxt = lb_rat;
            en_nxt = '0;
            inv_nxt = cfg_bad;
            state_nxt = cfg_bad ? FAULT_ST : LOCK_ST;
        end else begin
            unique case (state_r)
                IDLE_ST, FAULT_ST: en_nxt = '0;
                LOCK_ST: begin
                    en_nxt = domain_enable | pll_lock;
                    if (&en_nxt) begin
                        state_nxt = RUN_ST;
                    end
                end
                RUN_ST: en_nxt = domain_enable; // Lock loss is not re-gated
            endcase
        end
        // Read mux; unmapped offsets read zero
        if (rd_en) begin
            unique case (addr)
                ADDR_PLAT: rd_data_nxt = plat_r;
                ADDR_CLUS: rd_data_nxt = clus_r;
                ADDR_CSEL: rd_data_nxt = csel_r;
                ADDR_MEM: rd_data_nxt = mem_r;
                ADDR_MISC: rd_data_nxt = misc_r;
                ADDR_STAT: begin
                    rd_data_nxt[NUM_PLLS-1:0] = pll_lock;
                    rd_data_nxt[STAT_EN_LSB +: NUM_PLLS] = domain_enable;
                    rd_data_nxt[STAT_INV_BIT] = config_invalid;
                    rd_data_nxt[STAT_RUN_BIT] = (state_r == RUN_ST);
                end
                default: rd_data_nxt = '0;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            plat_r <= CFG_RST;
            clus_r <= CFG_RST;
            csel_r <= CFG_RST;
            mem_r <= CFG_RST;
            misc_r <= CFG_RST;
            cluster_a_set <= '0;
            cluster_b_set <= '0;
            platform_set <= '0;
            memory_set <= '0;
            lane_mult <= '0;
            core_clk <= '0;
            ddr_ref_platform <= 1'b0;
            mem_bus_half <= 1'b0;
            pme_div <= PME_DIV_RATIO;
            local_bus_div <= '0;
            domain_enable <= '0;
            config_invalid <= 1'b0;
            state_r <= IDLE_ST;
            rd_data <= '0;
        end else begin
            plat_r <= plat_nxt;
            clus_r <= clus_nxt;
            csel_r <= csel_nxt;
            mem_r <= mem_nxt;
            misc_r <= misc_nxt;
            cluster_a_set <= cla_nxt;
            cluster_b_set <= clb_nxt;
            platform_set <= plat_set_nxt;
            memory_set <= mem_set_nxt;
            lane_mult <= lane_nxt;
            core_clk <= core_nxt;
            ddr_ref_platform <= ddr_ref_nxt;
            mem_bus_half <= half_nxt;
            pme_div <= pme_nxt;
            local_bus_div <= lbd_nxt;
            domain_enable <= en_nxt;
            config_invalid <= inv_nxt;
            state_r <= state_nxt;
            rd_data <= rd_data_nxt;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    AST_GATE_LOCK: assert property (@(posedge clk) disable iff (!nrst)
        ((domain_enable & ~$past(domain_enable)) & ~$past(pll_lock)) == '0)
        else $error("domain enabled without lock");
    AST_INVALID_GATED: assert property (@(posedge clk) disable iff (!nrst)
        config_invalid |-> (domain_enable == '0))
        else $error("clock enabled under invalid configuration");
    AST_APPLY_BAD: assert property (@(posedge clk) disable iff (!nrst)
        (apply && cfg_bad) |=> config_invalid [*2])
        else $error("reserved code not flagged");
    AST_PLAT_RATIO: assert property (@(posedge clk) disable iff (!nrst)
        (state_r != IDLE_ST && !config_invalid) |->
        (platform_set.mult >= PLAT_RAT_MIN && platform_set.mult <= PLAT_RAT_MAX))
        else $error("platform ratio out of range");
    AST_CLUS_RATIO: assert property (@(posedge clk) disable iff (!nrst)
        (state_r != IDLE_ST && !config_invalid) |->
        (cluster_a_set.mult >= CLUS_RAT_MIN && cluster_a_set.mult <= CLUS_RAT_MAX &&
        cluster_b_set.mult >= CLUS_RAT_MIN && cluster_b_set.mult <= CLUS_RAT_MAX))
        else $error("cluster ratio out of range");
    AST_SYNC_CODE: assert property (@(posedge clk) disable iff (!nrst)
        (state_r != IDLE_ST && !config_invalid && ddr_ref_platform) |->
        (memory_set.mult == MEM_SYNC_CODE))
        else $error("sync mode with reserved memory code");
    AST_DDR_REF: assert property (@(posedge clk) disable iff (!nrst)
        apply |=> (ddr_ref_platform == $past(mem_sync)) && (mem_bus_half == ddr_ref_platform))
        else $error("ddr reference select mismatch");
    AST_CORE_DIV: assert property (@(posedge clk) disable iff (!nrst)
        !config_invalid |-> !(core_clk[0].src_b && core_clk[0].div2) &&
        !(core_clk[3].div2 && !core_clk[3].src_b))
        else $error("core divider outside allowed pairs");
    AST_LB_DIV: assert property (@(posedge clk) disable iff (!nrst)
        (domain_enable[PLL_PLAT] && !config_invalid) |-> (local_bus_div != '0))
        else $error("local bus divider zero while running");
    AST_PME_HALF: assert property (@(posedge clk) disable iff (!nrst)
        $rose(domain_enable[PLL_PLAT]) |-> (pme_div == PME_DIV_RATIO))
        else $error("pattern engine divider wrong");
    AST_STAT_READ: assert property (@(posedge clk) disable iff (!nrst)
        (rd_en && addr == ADDR_STAT) |=> (rd_data[STAT_INV_BIT] == $past(config_invalid)))
        else $error("status read mismatch");
endmodule : pll_ratio_clock_config

// file: verif/pll_lock_model.sv
// Behavioural PLL bank model that reports lock after each configuration apply
`timescale 1ns/1ps
module pll_lock_model
    import pll_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control from the bench
    input wire logic restart,
    input wire logic slow,
    // Lock reports
    output logic [pll_cfg_pkg::NUM_PLLS-1:0] pll_lock
);
    import pll_cfg_pkg::*;

    logic [5:0] count_r;

    // Cycles to lock; each PLL differs so enables must follow their own lock
    function automatic int lock_time(input int idx, input logic sl);
        return sl ? 3 * (idx + 1) + 5 : idx + 1;
    endfunction : lock_time

    // ****************************************
    // Lock sequencing
    // ****************************************
    // A new apply retunes every PLL, so lock drops and is regained later
    always_ff @(posedge clk) begin
        if (!nrst || restart) begin
            count_r <= 6'h00;
            pll_lock <= '0;
        end else begin
            if (count_r != 6'h3f) begin
                count_r <= count_r + 6'h01;
            end
            for (int i = 0; i < NUM_PLLS; i++) begin
                if (int'(count_r) >= lock_time(i, slow)) begin
                    pll_lock[i] <= 1'b1;
                end
            end
        end
    end
endmodule : pll_lock_model

// file: verif/testbench.sv
// Self-checking bench for the PLL ratio clock configuration block
`timescale 1ns/1ps
module testbench;
    import pll_cfg_pkg::*;
    logic clk, nrst, wr_en, rd_en, slow, apply;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data, v;
    logic [NUM_PLLS-1:0] pll_lock, domain_enable;
    pll_set_t cluster_a_set, cluster_b_set, platform_set, memory_set;
    logic [NUM_LANES-1:0][LANE_W-1:0] lane_mult;
    core_clk_t [NUM_CORES-1:0] core_clk;
    logic ddr_ref_platform, mem_bus_half, config_invalid;
    logic [1:0] pme_div;
    logic [RAT_W-1:0] local_bus_div;
    int failures, num_checks;
    // Staging words: plat, cluster, core select, memory, misc
    logic [ADDR_W-1:0] reg_addr [5] = '{ADDR_PLAT, ADDR_CLUS, ADDR_CSEL, ADDR_MEM, ADDR_MISC};
    // Sync DDR, range fields chosen per target frequency, sync bit set
    logic [31:0] cfg_a [5] = '{32'h0000_0004, 32'h0012_0108, 32'h0000_0541,
                               32'h0001_0101, 32'h0004_3202};
    // Async DDR with its own ratio; platform 8:1 so no core runs below it
    logic [31:0] cfg_b [5] = '{32'h0000_0108, 32'h0108_0012, 32'h0000_4400,
                               32'h0000_000a, 32'h0005_611f};
    // One reserved field each, applied on top of the first set
    int bad_idx [11] = '{0, 0, 1, 1, 2, 2, 2, 2, 3, 3, 4};
    logic [31:0] bad_val [11] = '{32'h003, 32'h00b, 32'h0012_0007, 32'h0013_0108, 32'h0545,
        32'h0141, 32'h0521, 32'hf541, 32'h0001_0102, 32'h0000_0000, 32'h0004_3200};

    assign apply = wr_en && (addr == ADDR_CTRL) && wr_data[APPLY_BIT];

    pll_ratio_clock_config i_pll_ratio_clock_config (
        .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .pll_lock(pll_lock),
        .cluster_a_set(cluster_a_set), .cluster_b_set(cluster_b_set),
        .platform_set(platform_set), .memory_set(memory_set), .lane_mult(lane_mult),
        .core_clk(core_clk), .ddr_ref_platform(ddr_ref_platform),
        .mem_bus_half(mem_bus_half), .pme_div(pme_div), .local_bus_div(local_bus_div),
        .domain_enable(domain_enable), .config_invalid(config_invalid));

    pll_lock_model i_pll_lock_model (
        .clk(clk), .nrst(nrst), .restart(apply), .slow(slow), .pll_lock(pll_lock));

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    // Compare and count; four-state compare so an unknown matches only an unknown
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle write strobe launched right after an edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

    // Stage a full set, apply it, check outputs once, then follow gating per cycle
    task automatic run_cfg(input logic [31:0] c [5], input logic ok, input logic [7:0] cc,
                           input logic sl);
        logic [NUM_PLLS-1:0] exp, lk;
        slow <= sl;
        for (int i = 0; i < 5; i++) begin
            wr(reg_addr[i], c[i]);
        end
        wr(ADDR_CTRL, 32'h0000_0001);
        #1;
        check(32'(config_invalid), 32'(!ok));
        check(32'(domain_enable), 32'h0);
        check(32'(pme_div), 32'h2);
        if (ok) begin
            check(32'(platform_set), 32'({c[0][4:0], c[0][9:8]}));
            check(32'(cluster_a_set), 32'({c[1][4:0], c[1][9:8]}));
            check(32'(cluster_b_set), 32'({c[1][20:16], c[1][25:24]}));
            check(32'(core_clk), 32'(cc));
            check(32'(memory_set), 32'({c[3][4:0], c[3][9:8]}));
            check(32'({ddr_ref_platform, mem_bus_half}), 32'({2{c[3][16]}}));
            check(32'(lane_mult), 32'({c[4][18:16], c[4][14:12], c[4][10:8]}));
            check(32'(local_bus_div), 32'(c[4][4:0]));
        end
        exp = '0;
        for (int k = 0; k < 40; k++) begin
            lk = pll_lock;
            @(posedge clk);
            #1;
            if (ok) begin
                exp = exp | lk;
            end
            check(32'(domain_enable), 32'(exp));
        end
        rd(ADDR_STAT, v);
        check(v, ok ? 32'h0002_7f7f : 32'h0001_007f);
    endtask : run_cfg

    // Verdict and end of run
    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Whole sequence needs about 780 cycles; allow a wide margin
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end

    initial begin
        logic [31:0] c [5];
        nrst = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = '0;
        wr_data = '0;
        slow = 1'b0;
        failures = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, read-only status, unmapped and write-only places
        @(posedge clk);
        #1;
        check(32'({domain_enable, config_invalid, platform_set}), 32'h0);
        check(32'(pme_div), 32'h2);
        wr(ADDR_STAT, 32'hffff_ffff);
        rd(ADDR_STAT, v);
        check(v & 32'hffff_ff80, 32'h0);
        rd(5'h1c, v);
        check(v, 32'h0);
        rd(ADDR_CTRL, v);
        check(v, 32'h0);
        $display("test reset_map done");
        // Two valid sets cover every core select code and both DDR modes
        run_cfg(cfg_a, 1'b1, 8'h39, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rd(reg_addr[i], v);
            check(v, cfg_a[i]);
        end
        run_cfg(cfg_b, 1'b1, 8'ha0, 1'b1);
        $display("test valid_sets done");
        // Each reserved code alone must block every domain
        for (int j = 0; j < 11; j++) begin
            c = cfg_a;
            c[bad_idx[j]] = bad_val[j];
            run_cfg(c, 1'b0, 8'h00, j[0]);
        end
        $display("test reserved_codes done");
        // Reset in mid-run drops every gate and setting
        run_cfg(cfg_a, 1'b1, 8'h39, 1'b0);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        #1;
        check(32'({domain_enable, config_invalid, platform_set, core_clk}), 32'h0);
        check(32'(pme_div), 32'h2);
        $display("test mid_reset done");
        results();
    end
endmodule : testbench
